// file: rtl/hbp_port.sv
// Host bus port with single-port RAM arbiter, clock divider and interrupt pin
`timescale 1ns/1ps
`include "hbp_consts.svh"
module hbp_port
    import hbp_pkg::*;
#(
    parameter int RAM_DEPTH = `HBP_RAM_DEPTH,
    parameter int GAP_MS_CYC = `HBP_GAP_MS_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] host_data_pins_i,
    output logic [7:0] host_data_pins_o,
    output logic host_data_pins_oe_o,
    input wire logic [15:0] host_address_pins_i,
    input wire logic write_strobe_or_eclk_i,
    input wire logic read_strobe_or_dir_i,
    input wire logic ext_select_n_i,
    input wire logic addr_latch_strobe_i,
    input wire logic [1:0] host_style_strap_i,
    input wire logic clk_div_strap_i,
    input wire logic float_all_test_n_i,
    input wire logic factory_test_n_i,
    output logic access_done_out_o,
    output logic access_done_out_oe_o,
    output logic divided_clock_out_o,
    output logic divided_clock_out_oe_o,
    output logic factory_test_mode_o,
    input wire logic irq_event_i,
    input wire logic irq_ack_command_i,
    input wire logic irq_gap_timebase_i,
    input wire logic irq_polarity_i,
    output logic irq_out_o,
    output logic irq_out_oe_o,
    input wire logic seq_req_i,
    input wire logic seq_we_i,
    input wire logic [`HBP_RAM_AW-1:0] seq_addr_i,
    input wire logic [7:0] seq_wdata_i,
    output logic seq_gnt_o,
    output logic [7:0] seq_rdata_o
);
    localparam logic [`HBP_GAP_W-1:0] GAP_US = `HBP_GAP_W'(`HBP_GAP_US_CYC);
    localparam logic [`HBP_GAP_W-1:0] GAP_MS = `HBP_GAP_W'(GAP_MS_CYC);

    logic [32:0] pins;
    logic [7:0] s_data;
    logic [15:0] s_addr;
    logic s_wr, s_rd, s_cs, s_ale, s_div, s_float_n, s_ftest_n;
    logic [1:0] s_strap;
    logic d_wr, d_rd, d_ale;
    hbp_acc_e state;
    logic op_write;
    logic [15:0] lat_addr;
    logic [7:0] wdata;
    logic [7:0] rd_hold;
    logic [7:0] ram_rdata;
    logic [1:0] div_cnt;
    logic irq_act;
    logic [`HBP_GAP_W-1:0] gap_cnt;
    logic mot, sync_mode, mux_mode, sel, rd_phase, cyc_end;
    logic rd_start, wr_start, ale_fall;
    logic host_take, seq_take, ram_en, ram_we;
    logic [`HBP_RAM_AW-1:0] ram_addr;
    logic [7:0] ram_wdata;
    logic next_div_out;

    // All pin inputs pass two flops before use
    hbp_sync #(.W(33), .RST(`HBP_PIN_RST)) u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .d_i({host_data_pins_i, host_address_pins_i, write_strobe_or_eclk_i,
              read_strobe_or_dir_i, ext_select_n_i, addr_latch_strobe_i,
              host_style_strap_i, clk_div_strap_i, float_all_test_n_i,
              factory_test_n_i}),
        .q_o(pins)
    );
    assign {s_data, s_addr, s_wr, s_rd, s_cs, s_ale, s_strap, s_div,
            s_float_n, s_ftest_n} = pins;

    // Delayed copies for edge detection
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            d_wr <= 1'b1;
            d_rd <= 1'b1;
            d_ale <= 1'b0;
        end else begin
            d_wr <= s_wr;
            d_rd <= s_rd;
            d_ale <= s_ale;
        end
    end

    // Mode decode from the two straps
    assign mot = s_strap[`HBP_STRAP_MOT]; // [R13]
    assign sync_mode = s_strap[`HBP_STRAP_SYNC]; // [R13]
    assign mux_mode = !mot && sync_mode; // [R14]
    assign ale_fall = d_ale && !s_ale; // [R10]

    // Selection: internal decoder in mux mode, external select otherwise
    assign sel = mux_mode ? (lat_addr[`HBP_CS_HI:`HBP_CS_LO] == 5'h00) // [R4]
                          : !s_cs; // [R14]

    // Strobe or E-clock interpretation of the shared control pins
    always_comb begin
        if (mot) begin
            rd_start = !d_wr && s_wr && s_rd; // [R8] [R9]
            wr_start = d_wr && !s_wr && !s_rd; // [R8] [R9]
            rd_phase = s_wr && s_rd;
            cyc_end = !s_wr;
        end else begin
            rd_start = d_rd && !s_rd; // [R15] [R9]
            wr_start = !d_wr && s_wr; // [R15] [R8]
            rd_phase = !s_rd;
            cyc_end = s_rd && s_wr;
        end
    end

    // Address latch; low byte comes from the data pins in mux mode
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lat_addr <= 16'h0000;
        end else if (ale_fall) begin
            lat_addr <= {s_addr[15:8], mux_mode ? s_data : s_addr[7:0]}; // [R10] [R14]
        end
    end

    // Host access sequence: request, load read data, hold until strobe ends
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= HBP_IDLE;
            op_write <= 1'b0;
            wdata <= 8'h00;
        end else begin
            unique case (state)
                HBP_IDLE: begin
                    if (sel && (rd_start || wr_start)) begin
                        state <= HBP_REQ;
                        op_write <= wr_start;
                        wdata <= s_data;
                    end
                end
                HBP_REQ: state <= HBP_LOAD;
                HBP_LOAD: state <= HBP_DONE;
                HBP_DONE: begin
                    if (cyc_end) begin
                        state <= HBP_IDLE;
                    end
                end
            endcase
        end
    end

    // Arbiter: host always wins, sequencer served in free cycles
    assign host_take = (state == HBP_REQ); // [R1]
    assign seq_take = seq_req_i && !host_take && !seq_gnt_o; // [R1]
    assign ram_en = host_take || seq_take; // [R2]
    assign ram_we = host_take ? op_write : seq_we_i;
    assign ram_addr = host_take ? lat_addr[`HBP_RAM_AW-1:0] : seq_addr_i;
    assign ram_wdata = host_take ? wdata : seq_wdata_i;

    // One single-port array shared by time multiplexing
    hbp_ram #(.DEPTH(RAM_DEPTH), .AW(`HBP_RAM_AW)) u_ram ( // [R2]
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .en_i(ram_en),
        .we_i(ram_we),
        .addr_i(ram_addr),
        .wdata_i(ram_wdata),
        .rdata_o(ram_rdata)
    );

    // Sequencer grant and read data one cycle after its access
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            seq_gnt_o <= 1'b0;
        end else begin
            seq_gnt_o <= seq_take; // [R1]
        end
    end
    assign seq_rdata_o = ram_rdata;

    // Host read data held so later sequencer reads cannot disturb it
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_hold <= 8'h00;
        end else if (state == HBP_LOAD && !op_write) begin
            rd_hold <= ram_rdata;
        end
    end

    // Data pins: driven only in a selected read, never in reset or float test
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            host_data_pins_o <= 8'h00; // [R5]
            host_data_pins_oe_o <= 1'b0; // [R5]
        end else begin
            host_data_pins_o <= rd_hold;
            host_data_pins_oe_o <= s_float_n && sel && rd_phase && !op_write
                                   && (state == HBP_DONE); // [R18] [R6]
        end
    end

    // Ready output, active low, only for selected asynchronous modes
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            access_done_out_o <= 1'b1;
            access_done_out_oe_o <= 1'b0;
        end else begin
            access_done_out_o <= !(state == HBP_DONE); // [R3]
            access_done_out_oe_o <= s_float_n && !sync_mode && sel
                                    && (state != HBP_IDLE || !cyc_end); // [R3] [R18] [R6]
        end
    end

    // Divided clock: bit 0 halves, bit 1 quarters the clock
    assign next_div_out = s_div ? div_cnt[0] : div_cnt[1]; // [R11]
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_cnt <= 2'b00;
            divided_clock_out_o <= 1'b0;
            divided_clock_out_oe_o <= 1'b0;
        end else begin
            div_cnt <= div_cnt + 2'b01;
            divided_clock_out_o <= next_div_out; // [R11]
            divided_clock_out_oe_o <= s_float_n; // [R6]
        end
    end

    // Production test flag follows the second test input
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            factory_test_mode_o <= 1'b0;
        end else begin
            factory_test_mode_o <= !s_ftest_n; // [R7]
        end
    end

    // Interrupt: acknowledge drops the request and starts the quiet gap
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_act <= 1'b0;
            gap_cnt <= '0;
        end else if (irq_ack_command_i) begin
            irq_act <= 1'b0;
            gap_cnt <= irq_gap_timebase_i ? GAP_MS : GAP_US; // [R16]
        end else if (gap_cnt != '0) begin
            irq_act <= 1'b0;
            gap_cnt <= gap_cnt - 1'b1; // [R16]
        end else begin
            irq_act <= irq_event_i;
        end
    end

    // Interrupt pin with selectable active level
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_out_o <= 1'b1;
            irq_out_oe_o <= 1'b0;
        end else begin
            irq_out_o <= irq_polarity_i ? irq_act : !irq_act; // [R17]
            irq_out_oe_o <= s_float_n; // [R6]
        end
    end

    // Checks kept beside the logic they guard
    property p_host_prio;
        @(posedge sys_clk_i) disable iff (rst_i)
        (state == HBP_REQ) |-> !seq_take ##1 !seq_gnt_o;
    endproperty
    a_host_prio: assert property (p_host_prio) else $error("sequencer served over host"); // [R1]

    property p_seq_gnt;
        @(posedge sys_clk_i) disable iff (rst_i)
        (seq_req_i && state == HBP_IDLE && !seq_gnt_o) |=> seq_gnt_o;
    endproperty
    a_seq_gnt: assert property (p_seq_gnt) else $error("free cycle not given to sequencer"); // [R2]

    property p_cs_decode;
        @(posedge sys_clk_i) disable iff (rst_i)
        (mux_mode && state == HBP_IDLE && (rd_start || wr_start)
         && lat_addr[15:11] != 5'h00) |=> state == HBP_IDLE;
    endproperty
    a_cs_decode: assert property (p_cs_decode) else $error("access with high address set"); // [R4]

    property p_reset_float;
        @(posedge sys_clk_i) rst_i |-> !host_data_pins_oe_o;
    endproperty
    a_reset_float: assert property (p_reset_float) else $error("data driven in reset"); // [R5]

    property p_float_test;
        @(posedge sys_clk_i) disable iff (rst_i)
        !s_float_n |=> !host_data_pins_oe_o && !access_done_out_oe_o
                       && !irq_out_oe_o && !divided_clock_out_oe_o;
    endproperty
    a_float_test: assert property (p_float_test) else $error("output driven in float test"); // [R6]

    property p_factory;
        @(posedge sys_clk_i) disable iff (rst_i)
        !s_ftest_n |=> factory_test_mode_o;
    endproperty
    a_factory: assert property (p_factory) else $error("test mode not entered"); // [R7]

    property p_div2;
        @(posedge sys_clk_i) disable iff (rst_i)
        s_div && $past(s_div) && $past(s_div, 2)
        |-> divided_clock_out_o != $past(divided_clock_out_o);
    endproperty
    a_div2: assert property (p_div2) else $error("clock out not halved"); // [R11]

    property p_irq_gap;
        @(posedge sys_clk_i) disable iff (rst_i)
        irq_ack_command_i |=> !irq_act [*8];
    endproperty
    a_irq_gap: assert property (p_irq_gap) else $error("interrupt inside quiet gap"); // [R16]

    property p_irq_pol;
        @(posedge sys_clk_i) disable iff (rst_i)
        irq_act && irq_polarity_i |=> irq_out_o;
    endproperty
    a_irq_pol: assert property (p_irq_pol) else $error("interrupt level wrong"); // [R17]

    property p_ready;
        @(posedge sys_clk_i) disable iff (rst_i)
        (state == HBP_REQ) |-> ##3 !access_done_out_o;
    endproperty
    a_ready: assert property (p_ready) else $error("ready not given after access"); // [R3]

    property p_strobe_write;
        @(posedge sys_clk_i) disable iff (rst_i)
        (!mot && sel && wr_start && state == HBP_IDLE) |=> state == HBP_REQ && op_write;
    endproperty
    a_strobe_write: assert property (p_strobe_write) else $error("write edge missed"); // [R15]
endmodule

// file: include/hbp_consts.svh
// Constants for the host bus port with shared-RAM arbiter
// Operation
// [R1] Host port wins RAM over microsequencer
// [R2] Buffer is one single-port 1.5k RAM
// [R3] Async modes drive an access-done output
// [R4] Mux mode selects when A15..A11 zero
// [R5] Data pins float during reset
// [R6] Float-test input low floats all outputs
// [R7] Factory-test input low enters test mode
// [R8] Shared pin: write strobe or E-clock
// [R9] Shared pin: read strobe or direction
// [R10] Address captured by latch strobe
// [R11] Clock out divided by 2 or 4
// [R12] Reset held at least 4 clocks
// [R13] Two straps pick one of four modes
// [R14] Mux mode latches low address, ignores select
// [R15] Read on strobe fall, write on rise
// [R16] Interrupt gap 1 us or 1 ms
// [R17] Interrupt polarity is selectable
// [R18] Drive data and ready only when selected
`ifndef HBP_CONSTS_SVH
`define HBP_CONSTS_SVH
`define HBP_RAM_DEPTH 1536
`define HBP_RAM_AW 11
`define HBP_CS_HI 15
`define HBP_CS_LO 11
`define HBP_STRAP_MOT 1
`define HBP_STRAP_SYNC 0
`define HBP_CLK_MHZ 200
`define HBP_GAP_US 1
`define HBP_GAP_MS 1
`define HBP_GAP_US_CYC (`HBP_GAP_US * `HBP_CLK_MHZ)
`define HBP_GAP_MS_CYC (`HBP_GAP_MS * 1000 * `HBP_CLK_MHZ)
`define HBP_GAP_W 18
`define HBP_RST_MIN_CYC 4
`define HBP_PIN_RST 33'h0_0000_01c3
`endif

// file: include/hbp_pkg.sv
// Types for the host bus port
package hbp_pkg;
    // Host access sequence, Gray coded along the loop
    typedef enum logic [1:0] {
        HBP_IDLE = 2'b00,
        HBP_REQ = 2'b01,
        HBP_LOAD = 2'b11,
        HBP_DONE = 2'b10
    } hbp_acc_e;
endpackage

// file: rtl/hbp_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module hbp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta;

    // First stage feeds only the second
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta <= RST;
            q_o <= RST;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule

// file: rtl/hbp_ram.sv
// Single-port buffer RAM in flip-flops
`timescale 1ns/1ps
module hbp_ram #(
    parameter int DEPTH = 1536,
    parameter int AW = 11
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire logic we_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [DEPTH];

    // One access per cycle; out-of-range writes are dropped
    always_ff @(posedge sys_clk_i) begin
        if (en_i && we_i && (int'(addr_i) < DEPTH)) begin
            mem[addr_i] <= wdata_i;
        end
    end

    // Registered read, out-of-range reads return zero
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else if (en_i && !we_i) begin
            rdata_o <= (int'(addr_i) < DEPTH) ? mem[addr_i] : 8'h00;
        end
    end
endmodule

// file: sim/hbp_host_model.sv
// Behavioural 8-bit host processor on the parallel bus
`timescale 1ns/1ps
module hbp_host_model (
    input wire logic sys_clk_i,
    input wire logic [1:0] style_i,
    input wire logic done_n_i,
    input wire logic done_oe_i,
    input wire logic [7:0] bus_i,
    output logic [15:0] addr_o,
    output logic pin_a_o,
    output logic pin_b_o,
    output logic ale_o,
    output logic [7:0] d_o,
    output logic d_oe_o,
    output logic rd_valid_o,
    output logic [7:0] rd_data_o
);
    // Start with strobes idle and the data pins released
    initial begin
        addr_o = 16'h0000;
        pin_a_o = 1'b1;
        pin_b_o = 1'b1;
        ale_o = 1'b0;
        d_o = 8'h00;
        d_oe_o = 1'b0;
        rd_valid_o = 1'b0;
        rd_data_o = 8'h00;
    end
    // Idle levels: strobes high, E-clock low, direction at read
    task automatic idle();
        pin_a_o = ~style_i[1];
        pin_b_o = 1'b1;
    endtask
    // One latch pulse per access; the multiplexed style puts the low byte on data
    task automatic addr_phase(input logic [15:0] a);
        @(negedge sys_clk_i);
        addr_o = a;
        ale_o = 1'b1;
        d_o = a[7:0];
        d_oe_o = (style_i == 2'b01);
        repeat (2) @(negedge sys_clk_i);
        ale_o = 1'b0;
        repeat (3) @(negedge sys_clk_i);
    endtask
    // Ready styles wait for the answer, rigid styles run a fixed cycle
    task automatic wait_answer();
        for (int n = 0; n < 16; n++) begin
            @(posedge sys_clk_i);
            if (!style_i[0] && done_oe_i && done_n_i === 1'b0) break;
        end
    endtask
    // Read cycle; data is taken at the edge where ready is seen
    task automatic rd(input logic [15:0] a);
        addr_phase(a);
        d_oe_o = 1'b0;
        if (style_i[1]) pin_a_o = 1'b1;
        else pin_b_o = 1'b0;
        wait_answer();
        rd_data_o = bus_i;
        rd_valid_o = 1'b1;
        @(negedge sys_clk_i);
        rd_valid_o = 1'b0;
        idle();
        repeat (6) @(negedge sys_clk_i);
    endtask
    // Write cycle; the strobe rise or the E fall carries the data in
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        addr_phase(a);
        d_o = v;
        d_oe_o = 1'b1;
        if (style_i[1]) pin_b_o = 1'b0;
        pin_a_o = style_i[1];
        repeat (4) @(negedge sys_clk_i);
        pin_a_o = ~style_i[1];
        wait_answer();
        @(negedge sys_clk_i);
        d_oe_o = 1'b0;
        idle();
        repeat (6) @(negedge sys_clk_i);
    endtask
endmodule

// file: sim/hbp_port_tb.sv
// Self-checking testbench for the host bus port
`timescale 1ns/1ps
module hbp_port_tb;
    localparam int GAP = 300;
    logic sys_clk_i, rst_i, sel_n, div2, flt_n, fac_n, ev, ack, tbase, pol, seq_req, seq_we;
    logic doe, rdy, rdy_oe, dclk, dclk_oe, fac_mode, irq, irq_oe, gnt, pa, pb, ale, hoe, rv;
    logic saw_doe, saw_roe, last;
    logic [1:0] style;
    logic [10:0] seq_addr;
    logic [7:0] seq_wd, pat, dout, rdat, hd, seq_rd, v;
    logic [15:0] haddr, a;
    logic [1:0] order [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
    logic [7:0] exp_q[$];
    wire [7:0] bus;
    int err_total, cmp_count, cyc, n;
    hbp_port #(.GAP_MS_CYC(GAP)) uut (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .host_data_pins_i(bus),
        .host_data_pins_o(dout), .host_data_pins_oe_o(doe), .host_address_pins_i(haddr),
        .write_strobe_or_eclk_i(pa), .read_strobe_or_dir_i(pb), .ext_select_n_i(sel_n),
        .addr_latch_strobe_i(ale), .host_style_strap_i(style), .clk_div_strap_i(div2),
        .float_all_test_n_i(flt_n), .factory_test_n_i(fac_n), .access_done_out_o(rdy),
        .access_done_out_oe_o(rdy_oe), .divided_clock_out_o(dclk),
        .divided_clock_out_oe_o(dclk_oe), .factory_test_mode_o(fac_mode), .irq_event_i(ev),
        .irq_ack_command_i(ack), .irq_gap_timebase_i(tbase), .irq_polarity_i(pol),
        .irq_out_o(irq), .irq_out_oe_o(irq_oe), .seq_req_i(seq_req), .seq_we_i(seq_we),
        .seq_addr_i(seq_addr), .seq_wdata_i(seq_wd), .seq_gnt_o(gnt), .seq_rdata_o(seq_rd));
    hbp_host_model host (
        .sys_clk_i(sys_clk_i), .style_i(style), .done_n_i(rdy), .done_oe_i(rdy_oe),
        .bus_i(bus), .addr_o(haddr), .pin_a_o(pa), .pin_b_o(pb), .ale_o(ale), .d_o(hd),
        .d_oe_o(hoe), .rd_valid_o(rv), .rd_data_o(rdat));
    // Data pin level: device, then host, else a pattern that keeps changing
    assign bus = doe ? dout : (hoe ? hd : pat);
    // Clock of 5 ns period
    initial begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end
    // Cycle count, floating pattern, drive flags and hang limit
    always @(posedge sys_clk_i) begin
        cyc++;
        pat <= pat + 8'h3b;
        if (doe) saw_doe <= 1'b1;
        if (rdy_oe) saw_roe <= 1'b1;
        if (cyc == 20000) begin
            err_total++;
            stop_test();
        end
    end
    // Each host read result is compared with the oldest expectation, while one is queued
    always @(posedge rv) begin
        if (exp_q.size() > 0) check(rdat, exp_q.pop_front());
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Sequencer access: request held until the grant is seen
    task automatic seq_acc(input logic we, input logic [10:0] ad, input logic [7:0] d);
        @(negedge sys_clk_i);
        seq_req = 1'b1;
        seq_we = we;
        seq_addr = ad;
        seq_wd = d;
        for (int k = 0; k < 20 && gnt !== 1'b1; k++) @(posedge sys_clk_i);
        if (!we) check(seq_rd, d);
        @(negedge sys_clk_i);
        seq_req = 1'b0;
    endtask
    // Reset for four cycles under a new host style
    task automatic set_mode(input logic [1:0] m);
        rst_i = 1'b1;
        style = m;
        sel_n = (m == 2'b01);
        host.idle();
        repeat (4) @(negedge sys_clk_i);
        check({7'h0, doe}, 8'h00);
        rst_i = 1'b0;
        repeat (4) @(negedge sys_clk_i);
        saw_doe = 1'b0;
        saw_roe = 1'b0;
    endtask
    // Main sequence
    initial begin
        rst_i = 1'b1;
        {sel_n, div2, flt_n, fac_n, ev, ack, tbase, pol, seq_req, seq_we} = 10'h0c0;
        {style, seq_addr, seq_wd, pat} = '0;
        {err_total, cmp_count, cyc} = '0;
        v = 8'($urandom(32'h51fd));
        repeat (8) @(negedge sys_clk_i);
        check({6'h0, doe, dclk}, 8'h00);
        foreach (order[i]) begin
            set_mode(order[i]);
            for (int k = 0; k < 2; k++) begin
                a = 16'($urandom_range(1535));
                v = 8'($urandom);
                host.wr(a, v);
                exp_q.push_back(v);
                host.rd(a);
            end
            check({7'h0, saw_roe}, {7'h0, ~order[i][0]});
        end
        host.wr(a, ~v);
        seq_acc(1'b0, a[10:0], ~v);
        seq_acc(1'b1, a[10:0] ^ 11'h001, v);
        exp_q.push_back(v);
        fork
            host.rd(a ^ 16'h0001);
            begin
                repeat (8) @(negedge sys_clk_i);
                seq_acc(1'b0, a[10:0], ~v);
            end
        join
        set_mode(2'b01);
        for (int b = 11; b < 16; b++) host.rd(16'(1 << b));
        check({6'h0, saw_doe, saw_roe}, 8'h00);
        set_mode(2'b00);
        sel_n = 1'b1;
        host.rd(16'h0010);
        check({6'h0, saw_doe, saw_roe}, 8'h00);
        for (int d = 0; d < 2; d++) begin
            div2 = d[0];
            repeat (4) @(negedge sys_clk_i);
            n = 0;
            for (int c = 0; c < 16; c++) begin
                last = dclk;
                @(negedge sys_clk_i);
                n += int'(dclk != last);
            end
            check(8'(n), d ? 8'h10 : 8'h08);
        end
        flt_n = 1'b0;
        fac_n = 1'b0;
        repeat (4) @(negedge sys_clk_i);
        check({4'h0, doe, rdy_oe, dclk_oe, irq_oe}, 8'h00);
        check({7'h0, fac_mode}, 8'h01);
        flt_n = 1'b1;
        fac_n = 1'b1;
        repeat (4) @(negedge sys_clk_i);
        check({6'h0, dclk_oe, fac_mode}, 8'h02);
        for (int i = 0; i < 4; i++) begin
            pol = i[0];
            tbase = i[1];
            ev = 1'b1;
            repeat (6) @(negedge sys_clk_i);
            check({7'h0, irq}, {7'h0, pol});
            ack = 1'b1;
            @(negedge sys_clk_i);
            ack = 1'b0;
            for (n = 0; n < 5 && irq === pol; n++) @(negedge sys_clk_i);
            for (n = 0; n < 2000 && irq !== pol; n++) @(negedge sys_clk_i);
            check({7'h0, n >= (tbase ? GAP : 200) - 4 && n <= (tbase ? GAP : 200) + 4}, 8'h01);
            ev = 1'b0;
            repeat (4) @(negedge sys_clk_i);
            check({7'h0, irq}, {7'h0, ~pol});
        end
        stop_test();
    end
endmodule
